// >>> shared/cod_pkg.sv
// Package for the clock-output divider: register map, field layout, reset values and state types
package cod_pkg;

  // Register byte offsets
  localparam logic [7:0] COD_OFS_CTRL0 = 8'h00;
  localparam logic [7:0] COD_OFS_CTRL1 = 8'h04;
  localparam logic [7:0] COD_OFS_SEL = 8'h08;
  localparam logic [7:0] COD_OFS_STAT = 8'h0c;

  // Field positions
  localparam int COD_GATE_BIT = 31;
  localparam int COD_RATIO_LSB = 0;
  localparam int COD_RATIO_W = 4;
  localparam int COD_SEL_W = 2;
  localparam int COD_PEND0_BIT = 17;
  localparam int COD_PEND1_BIT = 22;
  localparam int COD_STUCK0_BIT = 0;
  localparam int COD_STUCK1_BIT = 1;

  // Ratio encodings with special meaning
  localparam logic [3:0] COD_RATIO_DIV1 = 4'h0;
  localparam logic [3:0] COD_RATIO_DIV2 = 4'h1;
  localparam logic [3:0] COD_RATIO_DIV3 = 4'h2;

  // Reset values
  localparam logic COD_GATE_RST = 1'b0;
  localparam logic [3:0] COD_RATIO_RST = 4'h0;
  localparam logic [1:0] COD_SEL_RST = 2'h0;

  // Enable and ratio of one divider
  typedef struct packed {
    logic gate;
    logic [COD_RATIO_W-1:0] ratio;
  } cod_cfg_t;

  // Full state of one divider channel
  typedef struct packed {
    cod_cfg_t act;
    cod_cfg_t staged;
    logic pending;
    logic stuck;
    logic [COD_RATIO_W-1:0] cnt;
    logic srcPrev;
    logic divOut;
  } cod_chan_st_t;

  // Register-side state of the top level
  typedef struct packed {
    logic [COD_SEL_W-1:0] sel;
    logic [31:0] rdata;
  } cod_top_st_t;

endpackage

// >>> core/cod_div_chan.sv
// One clock-output divider channel with staged update, pending flag and stuck condition
`timescale 1ns/1ps
module cod_div_chan
  import cod_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  // Control from the register side and the phase reset request
  input wire logic phaseRst,
  input wire logic cfgWr,
  input wire cod_cfg_t cfgData,
  input wire logic selChange,
  // Selected source clock level
  input wire logic srcLevel,
  // Results
  output logic divClk,
  output logic pending,
  output logic stuck,
  output cod_cfg_t cfgView
);

  cod_chan_st_t stReg;
  cod_chan_st_t stNext;
  logic tick;
  logic [4:0] period;
  logic [4:0] half;
  logic wrap;

  assign tick = srcLevel & ~stReg.srcPrev;
  assign period = {1'b0, stReg.act.ratio} + 5'h01;
  assign half = 5'((period + 5'h01) >> 1);
  assign wrap = tick && ({1'b0, stReg.cnt} == period - 5'h01);

  // Next state; a new setting only lands when idle, at divide by one or at a period boundary so the output never glitches
  always_comb begin
    stNext = stReg;
    stNext.srcPrev = srcLevel;
    if (stReg.act.gate && !stReg.stuck) begin
      if (stReg.act.ratio == COD_RATIO_DIV1) begin
        stNext.divOut = srcLevel;
      end else if (tick) begin
        stNext.cnt = wrap ? '0 : stReg.cnt + 4'h1;
        stNext.divOut = ({1'b0, stNext.cnt} < half);
      end
    end else begin
      stNext.divOut = 1'b0;
      stNext.cnt = '0;
    end
    // Apply staged setting when idle, at divide by one, or at the end of a divided period
    if (stReg.pending && !stReg.stuck && (!stReg.act.gate || wrap || stReg.act.ratio == COD_RATIO_DIV1)) begin
      stNext.act = stReg.staged;
      stNext.pending = 1'b0;
      stNext.cnt = '0;
    end
    // A new write wins over the clear in the same cycle
    if (cfgWr) begin
      stNext.staged = cfgData;
      stNext.pending = 1'b1;
    end
    // Hazard: divide-by-two running across a select change or phase reset hangs the divider
    if ((selChange || phaseRst) && stReg.act.gate && stReg.act.ratio == COD_RATIO_DIV2) begin
      stNext.stuck = 1'b1;
    end
    if (phaseRst) begin
      stNext.act = '{gate: COD_GATE_RST, ratio: COD_RATIO_RST};
      stNext.staged = '{gate: COD_GATE_RST, ratio: COD_RATIO_RST};
      stNext.pending = 1'b0;
      stNext.cnt = '0;
      stNext.divOut = 1'b0;
    end
    if (stReg.stuck) begin
      stNext.divOut = 1'b0;
    end
  end

  // Only power-on reset clears a stuck divider
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stReg <= '0;
    end else begin
      stReg <= stNext;
    end
  end

  assign divClk = stReg.divOut;
  assign pending = stReg.pending;
  assign stuck = stReg.stuck;
  assign cfgView = stReg.staged;

  logic [3:0] cntNow;
  assign cntNow = stReg.cnt;

  a_gate_off_quiet: assert property (@(posedge clk) disable iff (!rstN)
    !stReg.act.gate |=> !divClk) else $error("divider output active while gate off");

  a_div2_shape: assert property (@(posedge clk) disable iff (!rstN)
    (stReg.act.gate && !stReg.stuck && stReg.act.ratio == COD_RATIO_DIV2 && tick && !phaseRst)
    |=> divClk == ($past(cntNow) == 4'h1)) else $error("divide by two shape wrong");

  // Two source periods high, one low: only the edge that moves the count from one to two drops the pin
  a_div3_shape: assert property (@(posedge clk) disable iff (!rstN)
    (stReg.act.gate && !stReg.stuck && stReg.act.ratio == COD_RATIO_DIV3 && tick && !phaseRst)
    |=> divClk == ($past(cntNow) != 4'h1)) else $error("divide by three shape wrong");

  a_pend_idle_clr: assert property (@(posedge clk) disable iff (!rstN)
    (pending && !stReg.act.gate && !stuck && !cfgWr) |=> !pending) else $error("pending not cleared while idle");

  a_write_pends: assert property (@(posedge clk) disable iff (!rstN)
    (cfgWr && !phaseRst) |=> (pending && cfgView == $past(cfgData))) else $error("write did not raise pending");

  a_stuck_entry: assert property (@(posedge clk) disable iff (!rstN)
    ((selChange || phaseRst) && stReg.act.gate && stReg.act.ratio == COD_RATIO_DIV2) |=> stuck)
    else $error("divide by two hazard not modelled");

  a_stuck_holds: assert property (@(posedge clk) disable iff (!rstN)
    stuck |=> (stuck && !divClk)) else $error("stuck divider recovered without power-on reset");

endmodule

// >>> core/cod_clock_output_divider.sv
// Clock-output divider block: register port, source select and two divider channels
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module cod_clock_output_divider
  import cod_pkg::*;
(
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Source clocks, sampled levels
  input wire logic [3:0] srcClk,
  // Phase 1 to 3 reset request, one-cycle pulse
  input wire logic phaseRst,
  // Divided clock outputs to pins
  output logic clockOutputZero,
  output logic clockOutputOne
);

  // Internal reset, register-side state and channel results
  logic [1:0] rstSyncReg;
  logic rstN;
  cod_top_st_t stReg;
  cod_top_st_t stNext;
  logic wrCtrl0;
  logic wrCtrl1;
  logic wrSel;
  logic selChange;
  logic srcLevel;
  cod_cfg_t wrCfg;
  logic [1:0] pend;
  logic [1:0] stuck;
  cod_cfg_t cfgView0;
  cod_cfg_t cfgView1;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSyncReg <= 2'h0;
    end else begin
      rstSyncReg <= {rstSyncReg[0], 1'b1};
    end
  end
  assign rstN = rstSyncReg[1];

  // Write decode
  assign wrCtrl0 = regWr && regAddr == COD_OFS_CTRL0;
  assign wrCtrl1 = regWr && regAddr == COD_OFS_CTRL1;
  assign wrSel = regWr && regAddr == COD_OFS_SEL;
  assign selChange = wrSel && regWdata[COD_SEL_W-1:0] != stReg.sel;
  assign wrCfg.gate = regWdata[COD_GATE_BIT];
  assign wrCfg.ratio = regWdata[COD_RATIO_LSB +: COD_RATIO_W];
  // Both outputs follow the one shared source selection
  assign srcLevel = srcClk[stReg.sel];

  // Select register and read data; unmapped reads return zero
  always_comb begin
    stNext = stReg;
    stNext.rdata = '0;
    if (wrSel) begin
      stNext.sel = regWdata[COD_SEL_W-1:0];
    end
    if (phaseRst) begin
      stNext.sel = COD_SEL_RST;
    end
    if (regRd) begin
      case (regAddr)
        COD_OFS_CTRL0: begin
          stNext.rdata[COD_GATE_BIT] = cfgView0.gate;
          stNext.rdata[COD_RATIO_LSB +: COD_RATIO_W] = cfgView0.ratio;
        end
        COD_OFS_CTRL1: begin
          stNext.rdata[COD_GATE_BIT] = cfgView1.gate;
          stNext.rdata[COD_RATIO_LSB +: COD_RATIO_W] = cfgView1.ratio;
        end
        COD_OFS_SEL: begin
          stNext.rdata[COD_SEL_W-1:0] = stReg.sel;
        end
        COD_OFS_STAT: begin
          stNext.rdata[COD_PEND0_BIT] = pend[0];
          stNext.rdata[COD_PEND1_BIT] = pend[1];
          stNext.rdata[COD_STUCK0_BIT] = stuck[0];
          stNext.rdata[COD_STUCK1_BIT] = stuck[1];
        end
        default: begin
          stNext.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stReg <= '{sel: COD_SEL_RST, rdata: 32'h0};
    end else begin
      stReg <= stNext;
    end
  end

  assign regRdata = stReg.rdata;

  // Output zero channel; software must stop the frequency monitor before gating it off
  cod_div_chan uChan0 (
    .clk(clk),
    .rstN(rstN),
    .phaseRst(phaseRst),
    .cfgWr(wrCtrl0),
    .cfgData(wrCfg),
    .selChange(selChange),
    .srcLevel(srcLevel),
    .divClk(clockOutputZero),
    .pending(pend[0]),
    .stuck(stuck[0]),
    .cfgView(cfgView0)
  );

  // Output one channel
  cod_div_chan uChan1 (
    .clk(clk),
    .rstN(rstN),
    .phaseRst(phaseRst),
    .cfgWr(wrCtrl1),
    .cfgData(wrCfg),
    .selChange(selChange),
    .srcLevel(srcLevel),
    .divClk(clockOutputOne),
    .pending(pend[1]),
    .stuck(stuck[1]),
    .cfgView(cfgView1)
  );

  // Status readback reports the pending bits of the cycle of the read
  a_stat_readback: assert property (@(posedge clk) disable iff (!rstN)
    (regRd && regAddr == COD_OFS_STAT) |=>
    (regRdata[COD_PEND0_BIT] == $past(pend[0]) && regRdata[COD_PEND1_BIT] == $past(pend[1])))
    else $error("pending bits misreported");

  a_sel_write: assert property (@(posedge clk) disable iff (!rstN)
    (wrSel && !phaseRst) |=> stReg.sel == $past(regWdata[COD_SEL_W-1:0])) else $error("source select not stored");

  // Read data stand for one cycle only and are zero between reads
  a_rd_idle_zero: assert property (@(posedge clk) disable iff (!rstN)
    !regRd |=> regRdata == 32'h0) else $error("read data present without a read");

  // Unmapped places read as zero; nothing else is signalled
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rstN)
    (regRd && regAddr != COD_OFS_CTRL0 && regAddr != COD_OFS_CTRL1 &&
    regAddr != COD_OFS_SEL && regAddr != COD_OFS_STAT) |=> regRdata == 32'h0)
    else $error("unmapped read returned data");

  // Control readback shows the staged enable and ratio, not the active one
  a_ctrl0_readback: assert property (@(posedge clk) disable iff (!rstN)
    (regRd && regAddr == COD_OFS_CTRL0) |=>
    (regRdata[COD_GATE_BIT] == $past(cfgView0.gate) &&
    regRdata[COD_RATIO_LSB +: COD_RATIO_W] == $past(cfgView0.ratio)))
    else $error("output zero control misreported");

  a_ctrl1_readback: assert property (@(posedge clk) disable iff (!rstN)
    (regRd && regAddr == COD_OFS_CTRL1) |=>
    (regRdata[COD_GATE_BIT] == $past(cfgView1.gate) &&
    regRdata[COD_RATIO_LSB +: COD_RATIO_W] == $past(cfgView1.ratio)))
    else $error("output one control misreported");

  // Stuck flags sit beside the pending bits in the status word
  a_stuck_readback: assert property (@(posedge clk) disable iff (!rstN)
    (regRd && regAddr == COD_OFS_STAT) |=>
    (regRdata[COD_STUCK0_BIT] == $past(stuck[0]) && regRdata[COD_STUCK1_BIT] == $past(stuck[1])))
    else $error("stuck flags misreported");

  // Phase reset returns the source selection to its reset value
  a_phase_sel_clear: assert property (@(posedge clk) disable iff (!rstN)
    phaseRst |=> stReg.sel == COD_SEL_RST) else $error("phase reset kept the source selection");

  // Only a select write or a phase reset moves the selection, so no stray change can hang a divider
  a_sel_hold: assert property (@(posedge clk) disable iff (!rstN)
    (!wrSel && !phaseRst) |=> $stable(stReg.sel)) else $error("source select moved without a write");

  // A write that no phase reset overrides always leaves an update pending
  a_wr_pend0: assert property (@(posedge clk) disable iff (!rstN)
    (wrCtrl0 && !phaseRst) |=> pend[0]) else $error("output zero write did not pend");
  a_wr_pend1: assert property (@(posedge clk) disable iff (!rstN)
    (wrCtrl1 && !phaseRst) |=> pend[1]) else $error("output one write did not pend");

  // With no update pending the staged setting is the active one, so gate off means a quiet pin
  a_out0_gated: assert property (@(posedge clk) disable iff (!rstN)
    (!cfgView0.gate && !pend[0]) |=> !clockOutputZero)
    else $error("output zero active while gated off");
  a_out1_gated: assert property (@(posedge clk) disable iff (!rstN)
    (!cfgView1.gate && !pend[1]) |=> !clockOutputOne)
    else $error("output one active while gated off");

  // A hung channel keeps its pin low until power-on reset
  a_out0_stuck_low: assert property (@(posedge clk) disable iff (!rstN)
    stuck[0] |=> !clockOutputZero)
    else $error("hung output zero toggled");
  a_out1_stuck_low: assert property (@(posedge clk) disable iff (!rstN)
    stuck[1] |=> !clockOutputOne)
    else $error("hung output one toggled");

  // Changing the source under a running divide-by-two hangs that channel
  a_sel_hazard0: assert property (@(posedge clk) disable iff (!rstN)
    (selChange && !pend[0] && cfgView0.gate && cfgView0.ratio == COD_RATIO_DIV2) |=> stuck[0])
    else $error("output zero survived a source change at divide by two");
  a_sel_hazard1: assert property (@(posedge clk) disable iff (!rstN)
    (selChange && !pend[1] && cfgView1.gate && cfgView1.ratio == COD_RATIO_DIV2) |=> stuck[1])
    else $error("output one survived a source change at divide by two");

endmodule

// >>> bench/cod_pin_monitor.sv
// Pin-side receiver model that measures the period of one divided clock output
`timescale 1ns/1ps
module cod_pin_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  // Watched output pin
  input wire logic pinLevel,
  // Span between the last two rising edges, in clock cycles, and rising-edge count
  output logic [7:0] lastPeriod,
  output logic [15:0] edgeCount
);
  logic pinPrev;
  logic [7:0] runCnt;

  // A receiver sees only edges, so a stuck pin shows as an edge count that stops moving
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pinPrev <= 1'b0;
      runCnt <= 8'h00;
      lastPeriod <= 8'h00;
      edgeCount <= 16'h0000;
    end else begin
      pinPrev <= pinLevel;
      if (pinLevel && !pinPrev) begin
        lastPeriod <= runCnt;
        runCnt <= 8'h01;
        edgeCount <= edgeCount + 16'h0001;
      end else begin
        runCnt <= runCnt + 8'h01; // Wraps only on very slow outputs, not used here
      end
    end
  end
endmodule

// >>> bench/cod_clock_output_divider_tb.sv
// Self-checking testbench for the clock-output divider block
`timescale 1ns/1ps
module cod_clock_output_divider_tb
  import cod_pkg::*;
;
  localparam logic [31:0] PEND0 = 32'h1 << COD_PEND0_BIT;
  localparam logic [31:0] PEND1 = 32'h1 << COD_PEND1_BIT;
  localparam logic [31:0] ALL = 32'hffffffff;
  logic clk;
  logic rst_n;
  logic [7:0] regAddr;
  logic [31:0] regWdata;
  logic regWr;
  logic regRd;
  logic [31:0] regRdata;
  logic [3:0] srcClk = 4'h0;
  logic phaseRst;
  logic clockOutputZero;
  logic clockOutputOne;
  logic [7:0] period0;
  logic [7:0] period1;
  logic [15:0] edges0;
  logic [15:0] edges1;
  logic [31:0] snap;
  int num_errors = 0;
  int comparisons = 0;

  cod_clock_output_divider u_cod_clock_output_divider (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .srcClk(srcClk),
    .phaseRst(phaseRst), .clockOutputZero(clockOutputZero), .clockOutputOne(clockOutputOne));
  cod_pin_monitor u_cod_pin_monitor0 (.clk(clk), .rstN(rst_n), .pinLevel(clockOutputZero),
    .lastPeriod(period0), .edgeCount(edges0));
  cod_pin_monitor u_cod_pin_monitor1 (.clk(clk), .rstN(rst_n), .pinLevel(clockOutputOne),
    .lastPeriod(period1), .edgeCount(edges1));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Source i has a period of 2 << i clock cycles
  always @(posedge clk) begin
    srcClk <= srcClk + 4'h1;
  end

  task automatic finish_test();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdChk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    snap = regRdata;
    check(snap & mask, exp);
  endtask

  // Bounded poll of the update-pending bits
  task automatic waitDone(input logic [31:0] mask);
    int n;
    n = 0;
    snap = mask;
    while ((snap & mask) !== 32'h0 && n < 60) begin
      @(posedge clk);
      regAddr <= COD_OFS_STAT;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      snap = regRdata;
      n++;
    end
    check(snap & mask, 32'h0);
  endtask

  task automatic pulsePhase();
    @(posedge clk);
    phaseRst <= 1'b1;
    @(posedge clk);
    phaseRst <= 1'b0;
  endtask

  task automatic noEdges0();
    logic [15:0] e;
    e = edges0;
    repeat (60) @(posedge clk);
    check({16'h0, edges0}, {16'h0, e});
  endtask

  task automatic noEdges1();
    logic [15:0] e;
    e = edges1;
    repeat (60) @(posedge clk);
    check({16'h0, edges1}, {16'h0, e});
  endtask

  // Watchdog: the sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test();
  end

  initial begin
    rst_n = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    phaseRst = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // Reset values, unmapped place ignored, gate off gives no clock
    rdChk(COD_OFS_CTRL0, ALL, 32'h0);
    rdChk(COD_OFS_SEL, ALL, 32'h0);
    rdChk(COD_OFS_STAT, ALL, 32'h0);
    wr(8'h10, ALL);
    rdChk(8'h10, ALL, 32'h0);
    rdChk(COD_OFS_CTRL1, ALL, 32'h0);
    noEdges0();
    // Divide by two on output zero, by three on output one, source 0
    wr(COD_OFS_CTRL0, 32'h80000001);
    wr(COD_OFS_CTRL1, 32'h80000002);
    waitDone(PEND0 | PEND1);
    repeat (40) @(posedge clk);
    check({24'h0, period0}, 32'h4);
    check({24'h0, period1}, 32'h6);
    // Safe source change of output zero, ending on a ratio other than two
    wr(COD_OFS_CTRL0, 32'h80000002);
    waitDone(PEND0);
    wr(COD_OFS_CTRL0, 32'h00000000);
    waitDone(PEND0);
    noEdges0();
    wr(COD_OFS_SEL, 32'h00000003);
    waitDone(PEND0);
    wr(COD_OFS_CTRL0, 32'h80000002);
    waitDone(PEND0);
    repeat (150) @(posedge clk);
    check({24'h0, period0}, 32'h30);
    check({24'h0, period1}, 32'h30);
    rdChk(COD_OFS_STAT, 32'h3, 32'h0);
    // Pending is held while a slow output finishes its period; start just after a boundary
    @(posedge clockOutputOne);
    wr(COD_OFS_CTRL1, 32'h80000003);
    rdChk(COD_OFS_STAT, PEND1, PEND1);
    rdChk(COD_OFS_CTRL1, ALL, 32'h80000003);
    waitDone(PEND1);
    repeat (200) @(posedge clk);
    check({24'h0, period1}, 32'h40);
    // Select change while divide by two runs: output zero hangs
    wr(COD_OFS_SEL, 32'h00000000);
    wr(COD_OFS_CTRL0, 32'h80000001);
    waitDone(PEND0);
    wr(COD_OFS_SEL, 32'h00000001);
    rdChk(COD_OFS_STAT, 32'h3, 32'h1);
    noEdges0();
    // Phase reset neither clears the hang nor lets updates through
    pulsePhase();
    rdChk(COD_OFS_STAT, 32'h3, 32'h1);
    rdChk(COD_OFS_CTRL0, ALL, 32'h0);
    wr(COD_OFS_CTRL0, 32'h80000002);
    repeat (30) @(posedge clk);
    rdChk(COD_OFS_STAT, PEND0, PEND0);
    noEdges0();
    // Power-on reset recovers; phase reset with divide by three is harmless
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rdChk(COD_OFS_STAT, ALL, 32'h0);
    wr(COD_OFS_CTRL0, 32'h80000002);
    waitDone(PEND0);
    pulsePhase();
    rdChk(COD_OFS_STAT, 32'h3, 32'h0);
    // Phase reset while output one divides by two: output one hangs
    wr(COD_OFS_CTRL1, 32'h80000001);
    waitDone(PEND1);
    pulsePhase();
    rdChk(COD_OFS_STAT, 32'h3, 32'h2);
    noEdges1();
    finish_test();
  end
endmodule
